// file: hdl/ctrl_sig_pkg.sv
// constants and types shared by the card control-signal logic
package ctrl_sig_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  // supply valid to usb d+ pull-up, seconds (nominal)
  localparam int unsigned POWER_TO_PULLUP_S = 12;
  // led pattern base step, milliseconds
  localparam int unsigned LED_STEP_MS = 100;
  localparam int unsigned LED_STEP_CYCLES = CLK_HZ / 1000 * LED_STEP_MS;
  // startup delay counted in the same 0.1 s steps as the led pattern
  localparam int unsigned PULLUP_STEPS = POWER_TO_PULLUP_S * 1000 / LED_STEP_MS;
  // pattern cycle is 20 steps of 0.1 s = 2 s
  localparam logic [4:0] LED_CYCLE_STEPS = 5'h14;
  localparam logic [4:0] LED_LAST_STEP = 5'h13;

  // operating status reported by the radio firmware
  typedef enum logic [1:0] {
    NO_SERVICE,
    REGISTERED,
    DIALED_UP,
    MIN_FUNCTION
  } led_pattern_t;

endpackage

// file: hdl/step_divider.sv
// free-running divider that emits a one-cycle enable every n cycles
`timescale 1ns/1ns
module step_divider
  import ctrl_sig_pkg::*;
#(
  parameter int unsigned DIV = 10
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic restart,
  output logic      tick
);

  localparam int unsigned W = $clog2(DIV + 1);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] count;

  // restart lets a new pattern or a fresh startup begin on a clean step boundary
  always_ff @(posedge clk_sys) begin
    if (sys_rst || restart) begin
      count <= '0;
    end else if (count == LAST) begin
      count <= '0;
    end else begin
      count <= count + W'(1);
    end
  end

  assign tick = (count == LAST) && !restart;

endmodule

// file: hdl/module_control_signals.sv
// card-side control signals: startup ordering, reset, wake, radio disable, status led
// How it works
// - reset held low stalls startup completion
// - raise usb d+ pull-up 12 s after power
// - software wake request pulls wake line low
// - reset input low resets the whole card
// - after reset, restart startup and report
// - open reset input reads as released
// - no service: 0.1 low/high/low, 1.7 high
// - registered 0.1 low 1.9 high; dial low
// - radio disable low turns radio off
`timescale 1ns/1ns
module module_control_signals
  import ctrl_sig_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = LED_STEP_CYCLES,
  parameter int unsigned STARTUP_STEPS = PULLUP_STEPS
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         card_reset_in_n,
  input  wire logic         radio_disable_n,
  input  wire logic         wake_request,
  input  wire logic         startup_report_enable,
  input  wire led_pattern_t led_pattern,
  output logic              usb_pullup_on,
  output logic              card_reset,
  output logic              startup_report,
  output logic              host_wake_out,
  output logic              host_wake_oe,
  output logic              radio_enable,
  output logic              link_status_led_n
);

  // =====================================================
  // pin synchronisers
  // =====================================================
  logic reset_meta;
  logic reset_sync_n;
  logic disable_meta;
  logic disable_sync_n;

  // synchroniser flops preset to released, so a floating pin
  // pulled up on the board reads as inactive
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reset_meta   <= 1'b1;
      reset_sync_n <= 1'b1;
    end else begin
      reset_meta   <= card_reset_in_n;
      reset_sync_n <= reset_meta;
    end
  end

  // radio pin gets the same two flops; only the second one is read
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      disable_meta   <= 1'b1;
      disable_sync_n <= 1'b1;
    end else begin
      disable_meta   <= radio_disable_n;
      disable_sync_n <= disable_meta;
    end
  end

  // =====================================================
  // led 0.1 s step enable
  // =====================================================
  logic step_tick;
  logic pattern_change;

  // zeroed on each status change so a new pattern starts on a full step
  step_divider #(
    .DIV (STEP_CYCLES)
  ) u_step (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .restart (pattern_change),
    .tick    (step_tick)
  );

  // =====================================================
  // hardware reset and startup sequence
  // =====================================================
  localparam int unsigned SW = $clog2(STARTUP_STEPS + 1);
  localparam logic [SW-1:0] STARTUP_LAST = SW'(STARTUP_STEPS);

  logic [SW-1:0] startup_count;
  logic          startup_done;
  logic          reset_held;

  // any low level on the pin holds the card in reset
  assign reset_held = !reset_sync_n;
  assign card_reset = reset_held;

  // startup keeps a divider of its own, restarted while the pin holds
  // the card in reset; sharing the led divider would let a busy status
  // input keep restarting the step and stall the pull-up for good
  logic startup_tick;

  step_divider #(
    .DIV (STEP_CYCLES)
  ) u_startup_step (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .restart (reset_held),
    .tick    (startup_tick)
  );

  // startup counts only while reset is released; a low pin restarts
  // the count from zero, so holding it stretches startup
  always_ff @(posedge clk_sys) begin
    if (sys_rst || reset_held) begin
      startup_count <= '0;
    end else if (!startup_done && startup_tick) begin
      startup_count <= startup_count + SW'(1);
    end
  end

  // the count parks at its last value, so done holds until the next reset
  assign startup_done = (startup_count == STARTUP_LAST);

  // d+ pull-up follows startup completion; dropped while in reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst || reset_held) begin
      usb_pullup_on <= 1'b0;
    end else begin
      usb_pullup_on <= startup_done;
    end
  end

  // one-cycle report at the moment startup completes, if enabled
  always_ff @(posedge clk_sys) begin
    if (sys_rst || reset_held) begin
      startup_report <= 1'b0;
    end else begin
      startup_report <= startup_done && !usb_pullup_on && startup_report_enable;
    end
  end

  // =====================================================
  // host wake, open collector
  // =====================================================
  // the pin only ever sinks; the host supplies the pull-up
  always_ff @(posedge clk_sys) begin
    if (sys_rst || reset_held) begin
      host_wake_oe <= 1'b0;
    end else begin
      host_wake_oe <= wake_request;
    end
  end

  // data side of the pin is tied low for good; only the enable moves,
  // so the card can never drive the line high against the host pull-up
  assign host_wake_out = 1'b0;

  // =====================================================
  // radio disable
  // =====================================================
  // gated by startup so the radio never runs before the card is up;
  // the pin acts three cycles after it moves: two sync flops and this one
  always_ff @(posedge clk_sys) begin
    if (sys_rst || reset_held) begin
      radio_enable <= 1'b0;
    end else begin
      radio_enable <= disable_sync_n && startup_done;
    end
  end

  // =====================================================
  // status led pattern
  // =====================================================
  led_pattern_t last_pattern;
  logic [4:0]   led_step;
  logic [4:0]   shown_step;
  logic         next_led_n;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      last_pattern <= MIN_FUNCTION;
    end else begin
      last_pattern <= led_pattern;
    end
  end

  // seen in the very cycle the status input moves
  assign pattern_change = (led_pattern != last_pattern);

  // step position within the 2 s cycle, zeroed on any status change
  always_ff @(posedge clk_sys) begin
    if (sys_rst || pattern_change) begin
      led_step <= '0;
    end else if (step_tick) begin
      led_step <= (led_step == LED_LAST_STEP) ? 5'h00 : led_step + 5'h01;
    end
  end

  // a status change shows step 0 at once, so the led never spends
  // one cycle on the new pattern at the old step position
  assign shown_step = pattern_change ? 5'h00 : led_step;

  always_comb begin
    case (led_pattern)
      NO_SERVICE:   next_led_n = !(shown_step == 5'h00 || shown_step == 5'h02);
      REGISTERED:   next_led_n = (shown_step != 5'h00);
      DIALED_UP:    next_led_n = 1'b0;
      MIN_FUNCTION: next_led_n = 1'b1;
      default:      next_led_n = 1'b1;
    endcase
  end

  // led dark while the card sits in reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst || reset_held) begin
      link_status_led_n <= 1'b1;
    end else begin
      link_status_led_n <= next_led_n;
    end
  end

endmodule

// file: testbench/ctrl_sig_properties.sv
// port-level assertions for the card control-signal block
`timescale 1ns/1ns
module ctrl_sig_properties
  import ctrl_sig_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         sys_rst,
  input wire logic         card_reset_in_n,
  input wire logic         radio_disable_n,
  input wire logic         wake_request,
  input wire logic         startup_report_enable,
  input wire led_pattern_t led_pattern,
  input wire logic         usb_pullup_on,
  input wire logic         card_reset,
  input wire logic         startup_report,
  input wire logic         host_wake_out,
  input wire logic         host_wake_oe,
  input wire logic         radio_enable,
  input wire logic         link_status_led_n
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  a_wake_data_low: assert property (host_wake_out == 1'h0)
    else $error("wake data not low");
  a_wake_follows_req: assert property (!card_reset [*2] |-> host_wake_oe == $past(wake_request))
    else $error("wake enable off request");
  a_reset_pin_acts: assert property (!card_reset_in_n [*2] |-> ##[0:1] card_reset)
    else $error("reset pin ignored");
  a_reset_all_quiet: assert property (card_reset [*2] |-> !usb_pullup_on
    && !radio_enable && link_status_led_n && !host_wake_oe && !startup_report)
    else $error("outputs active in reset");
  a_startup_restarts: assert property ($fell(card_reset) |-> !usb_pullup_on [*8])
    else $error("pull-up too early");
  a_report_with_pullup: assert property (startup_report |-> $rose(usb_pullup_on)
    && startup_report_enable)
    else $error("stray report pulse");
  a_radio_gate: assert property (radio_enable == (usb_pullup_on
    && $past(radio_disable_n, 3)))
    else $error("radio state off its gate");
  a_led_dial_low: assert property ((usb_pullup_on && !card_reset
    && led_pattern == DIALED_UP) [*3] |-> !link_status_led_n)
    else $error("led not low dialed");
  a_led_min_high: assert property ((usb_pullup_on && led_pattern == MIN_FUNCTION) [*3]
    |-> link_status_led_n)
    else $error("led not high at min");
  a_led_restart: assert property (usb_pullup_on && !card_reset && $changed(led_pattern)
    && led_pattern != MIN_FUNCTION |-> ##1 !link_status_led_n)
    else $error("pattern not restarted");
  c_report: cover property (startup_report);
  c_card_reset: cover property ($rose(card_reset));
  c_dial: cover property (led_pattern == DIALED_UP && !link_status_led_n);
  c_radio_off: cover property (usb_pullup_on && !radio_enable);
endmodule
bind module_control_signals ctrl_sig_properties u_ctrl_sig_properties (
  .clk_sys               (clk_sys),
  .sys_rst               (sys_rst),
  .card_reset_in_n       (card_reset_in_n),
  .radio_disable_n       (radio_disable_n),
  .wake_request          (wake_request),
  .startup_report_enable (startup_report_enable),
  .led_pattern           (led_pattern),
  .usb_pullup_on         (usb_pullup_on),
  .card_reset            (card_reset),
  .startup_report        (startup_report),
  .host_wake_out         (host_wake_out),
  .host_wake_oe          (host_wake_oe),
  .radio_enable          (radio_enable),
  .link_status_led_n     (link_status_led_n)
);

// file: testbench/host_model.sv
// host side: drives the reset pin, pulls the open-collector wake line up
`timescale 1ns/1ns
module host_model (
  input  wire logic clk_sys,
  input  wire logic host_wake_out,
  input  wire logic host_wake_oe,
  output logic      card_reset_in_n,
  output wire logic wake_line
);
  // the pull-up wins unless the card sinks the line
  assign wake_line = host_wake_oe ? host_wake_out : 1'h1;
  initial card_reset_in_n = 1'h1;
  // pulses stay far below the 1 s ceiling; released until startup ends
  task automatic pulse(input int n);
    @(negedge clk_sys);
    card_reset_in_n = 1'h0;
    repeat (n) @(negedge clk_sys);
    card_reset_in_n = 1'h1;
  endtask
endmodule

// file: testbench/module_control_signals_tb.sv
// self-checking bench for the card control-signal block
`timescale 1ns/1ns
module module_control_signals_tb;
  import ctrl_sig_pkg::*;
  logic         clk_sys = 1'h0;
  logic         sys_rst = 1'h1;
  logic         wake_request = 1'h0;
  logic         radio_disable_n = 1'h1;
  logic         startup_report_enable = 1'h1;
  led_pattern_t led_pattern = NO_SERVICE;
  logic         card_reset_in_n, wake_line, usb_pullup_on, card_reset, startup_report;
  logic         host_wake_out, host_wake_oe, radio_enable, link_status_led_n;
  logic [31:0]  seed = 32'h6A3E;
  int           error_cnt = 0;
  int           compares = 0;
  // short steps: 4 cycles per 0.1 s, startup of 3 steps
  module_control_signals #(
    .STEP_CYCLES   (4),
    .STARTUP_STEPS (3)
  ) u_module_control_signals (
    .clk_sys               (clk_sys),
    .sys_rst               (sys_rst),
    .card_reset_in_n       (card_reset_in_n),
    .radio_disable_n       (radio_disable_n),
    .wake_request          (wake_request),
    .startup_report_enable (startup_report_enable),
    .led_pattern           (led_pattern),
    .usb_pullup_on         (usb_pullup_on),
    .card_reset            (card_reset),
    .startup_report        (startup_report),
    .host_wake_out         (host_wake_out),
    .host_wake_oe          (host_wake_oe),
    .radio_enable          (radio_enable),
    .link_status_led_n     (link_status_led_n)
  );
  host_model u_host_model (
    .clk_sys         (clk_sys),
    .host_wake_out   (host_wake_out),
    .host_wake_oe    (host_wake_oe),
    .card_reset_in_n (card_reset_in_n),
    .wake_line       (wake_line)
  );
  initial forever #5 clk_sys = !clk_sys;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  // expected led level at a given step of a pattern
  function automatic logic exp_led(input led_pattern_t p, input int s);
    case (p)
      NO_SERVICE: return !(s == 0 || s == 2);
      REGISTERED: return s != 0;
      DIALED_UP:  return 1'h0;
      default:    return 1'h1;
    endcase
  endfunction
  task automatic chk(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // count cycles to pull-up; the report must come with it
  task automatic startup;
    int n;
    n = 0;
    while (usb_pullup_on !== 1'h1 && n < 30) begin
      @(negedge clk_sys);
      n++;
    end
    chk("startup time", 1'h1, n >= 12 && n <= 17);
    chk("report", startup_report_enable, startup_report);
  endtask
  initial begin
    repeat (3) @(negedge clk_sys);
    sys_rst = 1'h0;
    startup();
    $display("done startup");
    for (int p = 3; p < 7; p++) begin
      led_pattern = led_pattern_t'(p % 4);
      repeat (4) @(negedge clk_sys);
      for (int s = 0; s < 20; s++) begin
        chk("led", exp_led(led_pattern, s), link_status_led_n);
        repeat (4) @(negedge clk_sys);
      end
    end
    $display("done led");
    for (int i = 0; i < 30; i++) begin
      seed = xs(seed);
      wake_request = seed[0];
      @(negedge clk_sys);
      chk("wake line", !wake_request, wake_line);
    end
    wake_request = 1'h0;
    $display("done wake");
    startup_report_enable = 1'h0;
    seed = xs(seed);
    u_host_model.pulse(3 + seed[2:0]);
    chk("card reset", 1'h1, card_reset);
    chk("pullup off", 1'h0, usb_pullup_on);
    // the host leaves the pin alone until startup ends, then pulses again
    startup();
    startup_report_enable = 1'h1;
    repeat (6) @(negedge clk_sys);
    u_host_model.pulse(4);
    startup();
    $display("done reset");
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      radio_disable_n = (i < 2) ? 1'(i) : seed[1];
      repeat (5) @(negedge clk_sys);
      chk("radio", radio_disable_n, radio_enable);
    end
    $display("done radio");
    wrap_up();
  end
  initial begin
    #50000;
    error_cnt++;
    wrap_up();
  end
endmodule
